// *** common/ifb_pkg.sv ***
package ifb_pkg;
  // register byte addresses on the apb bus
  localparam logic [11:0] FLAG0_OFS = 12'h000;
  localparam logic [11:0] FLAG1_OFS = 12'h004;
  localparam logic [11:0] ENABLE0_OFS = 12'h008;
  localparam logic [11:0] ENABLE1_OFS = 12'h00C;
  localparam logic [11:0] REQUEST_OFS = 12'h010;
  // implemented bit masks; zero positions always read zero
  localparam logic [15:0] FLAG0_MASK = 16'hBFEF;
  localparam logic [15:0] FLAG1_MASK = 16'hFA1F;
  // reset values of flags and enables
  localparam logic [15:0] FLAG_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  // bit positions, first flag register
  localparam int MEMORY_PROGRAM_POS = 15;
  localparam int CONVERTER_DONE_POS = 13;
  localparam int SERIAL_A_TX_POS = 12;
  localparam int SERIAL_A_RX_POS = 11;
  localparam int SYNC_SERIAL_A_EVENT_POS = 10;
  localparam int SYNC_SERIAL_A_FAULT_POS = 9;
  localparam int TIMER_C_POS = 8;
  localparam int TIMER_B_POS = 7;
  localparam int COMPARE_B_POS = 6;
  localparam int CAPTURE_B_POS = 5;
  localparam int TIMER_A_POS = 3;
  localparam int COMPARE_A_POS = 2;
  localparam int CAPTURE_A_POS = 1;
  localparam int EXT_PIN_A_POS = 0;
  // bit positions, second flag register
  localparam int SERIAL_B_TX_POS = 15;
  localparam int SERIAL_B_RX_POS = 14;
  localparam int EXT_PIN_C_POS = 13;
  localparam int TIMER_E_POS = 12;
  localparam int TIMER_D_POS = 11;
  localparam int COMPARE_C_POS = 9;
  localparam int EXT_PIN_B_POS = 4;
  localparam int PIN_CHANGE_POS = 3;
  localparam int COMPARATOR_POS = 2;
  localparam int TWO_WIRE_A_MASTER_POS = 1;
  localparam int TWO_WIRE_A_SLAVE_POS = 0;
  // request register layout
  localparam int REQUEST_ANY_POS = 2;
endpackage : ifb_pkg

// *** core/ifb_flag_reg.sv ***
`timescale 1ns/1ps
// one 16-bit flag register: hardware sets, software writes
module ifb_flag_reg #(
  parameter logic [15:0] MASK = 16'hFFFF
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] set_i,
  input wire logic wr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] flag_o
);
  logic [15:0] flag;
  logic [15:0] next_flag;

  // a set in the same cycle as a software write of zero wins
  always_comb
  begin
    next_flag = flag;
    if (wr_i)
    begin
      next_flag = wdata_i;
    end
    next_flag = (next_flag | set_i) & MASK;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      flag <= ifb_pkg::FLAG_RESET;
    end
    else
    begin
      flag <= next_flag;
    end
  end

  assign flag_o = flag;
endmodule : ifb_flag_reg

// *** core/ifb_enable_reg.sv ***
`timescale 1ns/1ps
// one 16-bit enable register, software only
module ifb_enable_reg #(
  parameter logic [15:0] MASK = 16'hFFFF
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] enable_o
);
  logic [15:0] enable;
  logic [15:0] next_enable;

  always_comb
  begin
    next_enable = wr_i ? (wdata_i & MASK) : enable;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      enable <= ifb_pkg::ENABLE_RESET;
    end
    else
    begin
      enable <= next_enable;
    end
  end

  assign enable_o = enable;
endmodule : ifb_enable_reg

// *** core/ifb_flag_bank.sv ***
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
module ifb_flag_bank (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // event pulses, same clock domain, first register sources
  input wire logic MEMORY_PROGRAM_I,
  input wire logic CONVERTER_DONE_I,
  input wire logic SERIAL_A_TX_I,
  input wire logic SERIAL_A_RX_I,
  input wire logic SYNC_SERIAL_A_EVENT_I,
  input wire logic SYNC_SERIAL_A_FAULT_I,
  input wire logic TIMER_C_I,
  input wire logic TIMER_B_I,
  input wire logic COMPARE_B_I,
  input wire logic CAPTURE_B_I,
  input wire logic TIMER_A_I,
  input wire logic COMPARE_A_I,
  input wire logic CAPTURE_A_I,
  input wire logic EXT_PIN_A_I,
  // second register sources
  input wire logic SERIAL_B_TX_I,
  input wire logic SERIAL_B_RX_I,
  input wire logic EXT_PIN_C_I,
  input wire logic TIMER_E_I,
  input wire logic TIMER_D_I,
  input wire logic COMPARE_C_I,
  input wire logic EXT_PIN_B_I,
  input wire logic PIN_CHANGE_I,
  input wire logic COMPARATOR_I,
  input wire logic TWO_WIRE_A_MASTER_I,
  input wire logic TWO_WIRE_A_SLAVE_I,
  // flags and gated requests toward the cpu interrupt logic
  output logic [15:0] FLAG_STATUS_0_O,
  output logic [15:0] FLAG_STATUS_1_O,
  output logic [15:0] REQUEST_0_O,
  output logic [15:0] REQUEST_1_O,
  output logic REQUEST_ANY_O
);
  logic [15:0] set0;
  logic [15:0] set1;
  logic [15:0] flag_status_0;
  logic [15:0] flag_status_1;
  logic [15:0] enable_0;
  logic [15:0] enable_1;
  logic [15:0] req0;
  logic [15:0] req1;
  logic wr_phase;
  logic wr_f0;
  logic wr_f1;
  logic wr_e0;
  logic wr_e1;
  logic [15:0] wdata;
  logic addr_ok;
  logic [31:0] prdata;
  logic [31:0] next_prdata;
  logic pslverr;
  logic next_pslverr;

  // writes take effect in the access phase; zero wait states
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // merge partial writes by byte strobe so untouched bytes keep their flags
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] strb);
    merge = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
  endfunction : merge

  // source pulses placed at their flag positions
  always_comb
  begin
    set0 = 16'h0000;
    set0[ifb_pkg::MEMORY_PROGRAM_POS] = MEMORY_PROGRAM_I;
    set0[ifb_pkg::CONVERTER_DONE_POS] = CONVERTER_DONE_I;
    set0[ifb_pkg::SERIAL_A_TX_POS] = SERIAL_A_TX_I;
    set0[ifb_pkg::SERIAL_A_RX_POS] = SERIAL_A_RX_I;
    set0[ifb_pkg::SYNC_SERIAL_A_EVENT_POS] = SYNC_SERIAL_A_EVENT_I;
    set0[ifb_pkg::SYNC_SERIAL_A_FAULT_POS] = SYNC_SERIAL_A_FAULT_I;
    set0[ifb_pkg::TIMER_C_POS] = TIMER_C_I;
    set0[ifb_pkg::TIMER_B_POS] = TIMER_B_I;
    set0[ifb_pkg::COMPARE_B_POS] = COMPARE_B_I;
    set0[ifb_pkg::CAPTURE_B_POS] = CAPTURE_B_I;
    set0[ifb_pkg::TIMER_A_POS] = TIMER_A_I;
    set0[ifb_pkg::COMPARE_A_POS] = COMPARE_A_I;
    set0[ifb_pkg::CAPTURE_A_POS] = CAPTURE_A_I;
    set0[ifb_pkg::EXT_PIN_A_POS] = EXT_PIN_A_I;
  end

  always_comb
  begin
    set1 = 16'h0000;
    set1[ifb_pkg::SERIAL_B_TX_POS] = SERIAL_B_TX_I;
    set1[ifb_pkg::SERIAL_B_RX_POS] = SERIAL_B_RX_I;
    set1[ifb_pkg::EXT_PIN_C_POS] = EXT_PIN_C_I;
    set1[ifb_pkg::TIMER_E_POS] = TIMER_E_I;
    set1[ifb_pkg::TIMER_D_POS] = TIMER_D_I;
    set1[ifb_pkg::COMPARE_C_POS] = COMPARE_C_I;
    set1[ifb_pkg::EXT_PIN_B_POS] = EXT_PIN_B_I;
    set1[ifb_pkg::PIN_CHANGE_POS] = PIN_CHANGE_I;
    set1[ifb_pkg::COMPARATOR_POS] = COMPARATOR_I;
    set1[ifb_pkg::TWO_WIRE_A_MASTER_POS] = TWO_WIRE_A_MASTER_I;
    set1[ifb_pkg::TWO_WIRE_A_SLAVE_POS] = TWO_WIRE_A_SLAVE_I;
  end

  // apb write decode
  assign wr_phase = PSEL_I & PENABLE_I & PWRITE_I;
  assign wr_f0 = wr_phase & hit(PADDR_I, ifb_pkg::FLAG0_OFS);
  assign wr_f1 = wr_phase & hit(PADDR_I, ifb_pkg::FLAG1_OFS);
  assign wr_e0 = wr_phase & hit(PADDR_I, ifb_pkg::ENABLE0_OFS);
  assign wr_e1 = wr_phase & hit(PADDR_I, ifb_pkg::ENABLE1_OFS);
  assign addr_ok = hit(PADDR_I, ifb_pkg::FLAG0_OFS) | hit(PADDR_I, ifb_pkg::FLAG1_OFS)
                 | hit(PADDR_I, ifb_pkg::ENABLE0_OFS) | hit(PADDR_I, ifb_pkg::ENABLE1_OFS)
                 | hit(PADDR_I, ifb_pkg::REQUEST_OFS);

  // flag registers: sticky, set beats a clearing write
  ifb_flag_reg #(.MASK(ifb_pkg::FLAG0_MASK)) u_flag0 (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .set_i(set0),
    .wr_i(wr_f0),
    .wdata_i(merge(flag_status_0, PWDATA_I, PSTRB_I)),
    .flag_o(flag_status_0)
  );

  ifb_flag_reg #(.MASK(ifb_pkg::FLAG1_MASK)) u_flag1 (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .set_i(set1),
    .wr_i(wr_f1),
    .wdata_i(merge(flag_status_1, PWDATA_I, PSTRB_I)),
    .flag_o(flag_status_1)
  );

  // companion enables share each flag's bit position
  ifb_enable_reg #(.MASK(ifb_pkg::FLAG0_MASK)) u_en0 (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .wr_i(wr_e0),
    .wdata_i(merge(enable_0, PWDATA_I, PSTRB_I)),
    .enable_o(enable_0)
  );

  ifb_enable_reg #(.MASK(ifb_pkg::FLAG1_MASK)) u_en1 (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .wr_i(wr_e1),
    .wdata_i(merge(enable_1, PWDATA_I, PSTRB_I)),
    .enable_o(enable_1)
  );

  // a flag becomes a request only when enabled; combinational, no added latency
  assign req0 = flag_status_0 & enable_0;
  assign req1 = flag_status_1 & enable_1;

  // read data registered in the setup phase, presented in the access phase
  always_comb
  begin
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (PSEL_I && !PENABLE_I)
    begin
      next_prdata = 32'h0000_0000;
      next_pslverr = ~addr_ok;
      if (!PWRITE_I)
      begin
        unique case (1'b1)
          hit(PADDR_I, ifb_pkg::FLAG0_OFS): next_prdata = {16'h0000, flag_status_0};
          hit(PADDR_I, ifb_pkg::FLAG1_OFS): next_prdata = {16'h0000, flag_status_1};
          hit(PADDR_I, ifb_pkg::ENABLE0_OFS): next_prdata = {16'h0000, enable_0};
          hit(PADDR_I, ifb_pkg::ENABLE1_OFS): next_prdata = {16'h0000, enable_1};
          hit(PADDR_I, ifb_pkg::REQUEST_OFS): next_prdata = {29'h0000_0000, |(req0 | req1), |req1, |req0};
          default: next_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  assign PRDATA_O = prdata;
  assign PSLVERR_O = pslverr & PSEL_I & PENABLE_I; // unmapped address errors, write is dropped
  assign PREADY_O = 1'b1; // never waits: every access ends after one access cycle
  assign FLAG_STATUS_0_O = flag_status_0;
  assign FLAG_STATUS_1_O = flag_status_1;
  assign REQUEST_0_O = req0;
  assign REQUEST_1_O = req1;
  assign REQUEST_ANY_O = |(req0 | req1);
endmodule : ifb_flag_bank

// *** bench/ifb_event_src.sv ***
`timescale 1ns/1ps
// peripheral side: a fire request becomes an event one cycle later
module ifb_event_src (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] fire0_i,
  input wire logic [15:0] fire1_i,
  output logic [15:0] ev0_o,
  output logic [15:0] ev1_o
);
  logic [15:0] next_ev0;
  logic [15:0] next_ev1;
  // registered so events change just after an edge, like a real source
  always_comb
  begin
    next_ev0 = fire0_i;
    next_ev1 = fire1_i;
  end
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ev0_o <= 16'h0000;
      ev1_o <= 16'h0000;
    end
    else
    begin
      ev0_o <= next_ev0;
      ev1_o <= next_ev1;
    end
  end
endmodule : ifb_event_src

// *** bench/ifb_flag_bank_properties.sv ***
`timescale 1ns/1ps
// flag, request and write relations seen at the bank ports
module ifb_flag_bank_chk (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  input wire logic EXT_PIN_A_I,
  input wire logic TIMER_A_I,
  input wire logic TIMER_B_I,
  input wire logic TIMER_C_I,
  input wire logic SERIAL_B_TX_I,
  input wire logic TWO_WIRE_A_SLAVE_I,
  input wire logic [15:0] FLAG_STATUS_0_O,
  input wire logic [15:0] FLAG_STATUS_1_O,
  input wire logic [15:0] REQUEST_0_O,
  input wire logic [15:0] REQUEST_1_O,
  input wire logic REQUEST_ANY_O
);
  logic wr0;
  logic wr1;
  // ready is always high, so every write access phase is a write edge
  assign wr0 = PSEL_I & PENABLE_I & PWRITE_I & (PADDR_I == ifb_pkg::FLAG0_OFS);
  assign wr1 = PSEL_I & PENABLE_I & PWRITE_I & (PADDR_I == ifb_pkg::FLAG1_OFS);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_set_ext_pin: assert property (EXT_PIN_A_I |=> FLAG_STATUS_0_O[0])
    else $error("pin event lost");
  a_map_upper0: assert property (TIMER_C_I |=> FLAG_STATUS_0_O[8])
    else $error("timer c flag lost");
  a_map_lower0: assert property (TIMER_B_I |=> FLAG_STATUS_0_O[7])
    else $error("timer b flag lost");
  a_map_upper1: assert property (SERIAL_B_TX_I |=> FLAG_STATUS_1_O[15])
    else $error("serial b flag lost");
  a_holes_zero: assert property ((FLAG_STATUS_0_O & ~ifb_pkg::FLAG0_MASK) == 16'h0000
    && (FLAG_STATUS_1_O & ~ifb_pkg::FLAG1_MASK) == 16'h0000) else $error("hole reads one");
  a_req_gated: assert property ((REQUEST_0_O & ~FLAG_STATUS_0_O) == 16'h0000
    && (REQUEST_1_O & ~FLAG_STATUS_1_O) == 16'h0000
    && REQUEST_ANY_O == |{REQUEST_0_O, REQUEST_1_O}) else $error("request without flag");
  a_flag_hold: assert property (FLAG_STATUS_0_O[15] && !wr0 |=> FLAG_STATUS_0_O[15])
    else $error("flag dropped");
  a_set_wins: assert property (wr0 && TIMER_A_I |=> FLAG_STATUS_0_O[3])
    else $error("clear beat event");
  a_sw_clear: assert property (wr1 && PSTRB_I[0] && !PWDATA_I[0] && !TWO_WIRE_A_SLAVE_I
    |=> !FLAG_STATUS_1_O[0]) else $error("clear ignored");
endmodule : ifb_flag_bank_chk

bind ifb_flag_bank ifb_flag_bank_chk u_ifb_flag_bank_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I), .EXT_PIN_A_I(EXT_PIN_A_I), .TIMER_A_I(TIMER_A_I),
  .TIMER_B_I(TIMER_B_I), .TIMER_C_I(TIMER_C_I), .SERIAL_B_TX_I(SERIAL_B_TX_I),
  .TWO_WIRE_A_SLAVE_I(TWO_WIRE_A_SLAVE_I), .FLAG_STATUS_0_O(FLAG_STATUS_0_O),
  .FLAG_STATUS_1_O(FLAG_STATUS_1_O), .REQUEST_0_O(REQUEST_0_O), .REQUEST_1_O(REQUEST_1_O),
  .REQUEST_ANY_O(REQUEST_ANY_O));

// *** bench/ifb_flag_bank_bench.sv ***
`timescale 1ns/1ps
module ifb_flag_bank_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [15:0] fire0 = 16'h0;
  logic [15:0] fire1 = 16'h0;
  logic [15:0] ev0;
  logic [15:0] ev1;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] flag0;
  logic [15:0] flag1;
  logic [15:0] req0;
  logic [15:0] req1;
  logic req_any;
  logic [31:0] rd;
  logic er;
  int bad_count = 0;
  int n_compared = 0;
  // rows: event code, first flags, second flags; the second register fires the inverse code
  // so a source wired into the wrong register shows up as well as a swap inside one
  logic [47:0] rows [5] = '{48'hAAAA_AAAA_5015, 48'hCCCC_8CCC_3213, 48'hF0F0_B0E0_0A0F,
    48'hFF00_BF00_001F, 48'h5555_1545_AA0A};
  ifb_event_src u_ifb_event_src (.clk_i(clk), .rst_n_i(rst_n), .fire0_i(fire0), .fire1_i(fire1),
    .ev0_o(ev0), .ev1_o(ev1));
  ifb_flag_bank u_ifb_flag_bank (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr),
    // sources wired by flag position
    .MEMORY_PROGRAM_I(ev0[15]), .CONVERTER_DONE_I(ev0[13]), .SERIAL_A_TX_I(ev0[12]),
    .SERIAL_A_RX_I(ev0[11]), .SYNC_SERIAL_A_EVENT_I(ev0[10]), .SYNC_SERIAL_A_FAULT_I(ev0[9]),
    .TIMER_C_I(ev0[8]), .TIMER_B_I(ev0[7]), .COMPARE_B_I(ev0[6]), .CAPTURE_B_I(ev0[5]),
    .TIMER_A_I(ev0[3]), .COMPARE_A_I(ev0[2]), .CAPTURE_A_I(ev0[1]), .EXT_PIN_A_I(ev0[0]),
    .SERIAL_B_TX_I(ev1[15]), .SERIAL_B_RX_I(ev1[14]), .EXT_PIN_C_I(ev1[13]), .TIMER_E_I(ev1[12]),
    .TIMER_D_I(ev1[11]), .COMPARE_C_I(ev1[9]), .EXT_PIN_B_I(ev1[4]), .PIN_CHANGE_I(ev1[3]),
    .COMPARATOR_I(ev1[2]), .TWO_WIRE_A_MASTER_I(ev1[1]), .TWO_WIRE_A_SLAVE_I(ev1[0]),
    .FLAG_STATUS_0_O(flag0), .FLAG_STATUS_1_O(flag1), .REQUEST_0_O(req0), .REQUEST_1_O(req1),
    .REQUEST_ANY_O(req_any));
  initial
  begin
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; f fires first-register events so they land on the access edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [15:0] f, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    fire0 <= f;
    @(posedge clk);
    pen <= 1'b1;
    fire0 <= 16'h0;
    @(posedge clk);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge clk);
      n++;
    end
    // a slave that never answers ends the run as a failure
    if (n == 16)
    begin
      bad_count++;
      tally_and_finish;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // hang guard; the run needs well under a thousand cycles
  initial
  begin
    repeat (3000) @(posedge clk);
    bad_count++;
    tally_and_finish;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, ifb_pkg::FLAG0_OFS, 32'h0, 4'h0, 16'h0, rd, er);
    chk(rd, 32'h0);
    chk(32'(er), 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      fire0 <= rows[i][47:32];
      fire1 <= ~rows[i][47:32];
      @(posedge clk);
      fire0 <= 16'h0;
      fire1 <= 16'h0;
      repeat (2) @(posedge clk);
      apb(1'b0, ifb_pkg::FLAG0_OFS, 32'h0, 4'h0, 16'h0, rd, er);
      chk(rd, 32'(rows[i][31:16]));
      apb(1'b0, ifb_pkg::FLAG1_OFS, 32'h0, 4'h0, 16'h0, rd, er);
      chk(rd, 32'(rows[i][15:0]));
      chk(32'(req0 | req1), 32'h0);
      apb(1'b1, ifb_pkg::FLAG0_OFS, 32'h0, 4'hF, 16'h0, rd, er);
      apb(1'b1, ifb_pkg::FLAG1_OFS, 32'h0, 4'hF, 16'h0, rd, er);
    end
    // software sets every flag; holes stay zero
    apb(1'b1, ifb_pkg::FLAG0_OFS, 32'hFFFF, 4'hF, 16'h0, rd, er);
    apb(1'b1, ifb_pkg::FLAG1_OFS, 32'hFFFF, 4'hF, 16'h0, rd, er);
    apb(1'b0, ifb_pkg::FLAG0_OFS, 32'h0, 4'h0, 16'h0, rd, er);
    chk(rd, 32'hBFEF);
    // low strobe alone clears only the low byte
    apb(1'b1, ifb_pkg::FLAG1_OFS, 32'h0, 4'h1, 16'h0, rd, er);
    apb(1'b0, ifb_pkg::FLAG1_OFS, 32'h0, 4'h0, 16'h0, rd, er);
    chk(rd, 32'hFA00);
    // one enable bit passes exactly one request
    apb(1'b1, ifb_pkg::ENABLE0_OFS, 32'h0008, 4'hF, 16'h0, rd, er);
    chk(32'(req0), 32'h0008);
    chk(32'(req1), 32'h0);
    chk(32'(req_any), 32'h1);
    apb(1'b0, ifb_pkg::REQUEST_OFS, 32'h0, 4'h0, 16'h0, rd, er);
    chk(rd, 32'h5);
    // clear racing a timer event on the same edge
    apb(1'b1, ifb_pkg::FLAG0_OFS, 32'h0, 4'hF, 16'h0008, rd, er);
    apb(1'b0, ifb_pkg::FLAG0_OFS, 32'h0, 4'h0, 16'h0, rd, er);
    chk(rd, 32'h0008);
    // unmapped place gives an error and zero
    apb(1'b0, 12'h020, 32'h0, 4'h0, 16'h0, rd, er);
    chk(rd, 32'h0);
    chk(32'(er), 32'h1);
    // reset in mid-run clears flags and enables
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'(flag0), 32'h0);
    chk(32'(flag1), 32'h0);
    chk(32'(req_any), 32'h0);
    chk(32'(pready), 32'h1);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, ifb_pkg::ENABLE0_OFS, 32'h0, 4'h0, 16'h0, rd, er);
    chk(rd, 32'h0);
    tally_and_finish;
  end
endmodule : ifb_flag_bank_bench
